// File: rtl/pcs_pkg.sv
// Purpose: shared constants and types of the procedure call stack unit
// Assumes: 16-bit memory words, pointers are segment word plus word number
// Notes: ring sits in two bits of the segment word of a pointer
package pcs_pkg;
  // ring field inside a pointer's segment word
  localparam int RING_HI = 14;
  localparam int RING_LO = 13;
  // stack root segment layout
  localparam logic [15:0] FP_WORD = 16'h0000;
  localparam logic [15:0] EXT_WORD = 16'h0002;
  // frame header layout
  localparam logic [15:0] HDR_PB = 16'h0002;
  localparam logic [15:0] HDR_SB = 16'h0004;
  localparam logic [15:0] HDR_LB = 16'h0006;
  localparam logic [15:0] HDR_KEYS = 16'h0008;
  localparam logic [15:0] HDR_PC_WORD = 16'h0009;
  localparam logic [15:0] HDR_LEN = 16'h000A;
  localparam logic [15:0] ARG_BASE = 16'h000A;
  localparam logic [15:0] PR_LEN = 16'h0007;
  // entry control block layout
  localparam logic [15:0] ECB_PB = 16'h0000;
  localparam logic [15:0] ECB_SIZE = 16'h0002;
  localparam logic [15:0] ECB_ROOT = 16'h0003;
  localparam logic [15:0] ECB_ARGUMENT_COUNT_FIELD = 16'h0004;
  localparam logic [15:0] ECB_LB = 16'h0005;
  localparam logic [15:0] ECB_KEYS = 16'h0007;
  localparam logic [15:0] ECB_LEN = 16'h0008;
  localparam logic [15:0] GATE_MASK = 16'h000F;
  // misc values
  localparam logic [15:0] PCL_LEN = 16'h0002;
  localparam logic [15:0] OMIT_PTR = 16'h8000;
  localparam logic [15:0] RTN_PC_OFS = 16'h0001;
  // pointer: segment word and word number
  typedef struct packed {
    logic [15:0] seg;
    logic [15:0] word;
  } pcs_ptr_t;
  // architectural state touched by this unit
  typedef struct packed {
    pcs_ptr_t pc;
    pcs_ptr_t sb;
    pcs_ptr_t lb;
    logic [15:0] keys;
    logic [15:0] y;
    logic [15:0] s;
    logic [31:0] l;
  } pcs_arch_t;
  // memory request
  typedef struct packed {
    logic req;
    logic we;
    pcs_ptr_t addr;
    logic [15:0] wdata;
  } pcs_mreq_t;
  typedef enum logic [2:0] {
    jump_save_word_number, procedure_call_op, procedure_return_op,
    recursive_return_op, stack_extend_op, execute_at_address_op
  } pcs_op_t;
  typedef enum logic [1:0] {
    fault_none, fault_access, fault_overflow, stack_underflow_fault
  } pcs_fault_t;
endpackage : pcs_pkg

// File: rtl/pcs_unit.sv
// Purpose: procedure linkage sequencer over segmented stack memory
// Assumes: memory answers each held request with a one-cycle ack
// Notes: architectural state goes out on arch, valid with done
// Behaviour
// RULE1: jump-save keeps word number in Y
// RULE2: read access keeps current ring
// RULE3: gate access takes ring from block
// RULE4: neither access raises access violation
// RULE5: allocate at free pointer, advance it
// RULE6: no room follows extension, zero faults
// RULE7: frame flag word cleared to zero
// RULE8: save caller bases, keys and ring
// RULE9: word octal 11 holds call plus two
// RULE10: load callee state, stack base to frame
// RULE11: zero count skips argument transfer
// RULE12: program places templates to match count
// RULE13: return frees frame, restores weakened state
// RULE14: return reclaims frame and its extensions
// RULE15: recursive return loads pc then S
// RULE16: zero return address faults, S kept
// RULE17: extend rounds size even, returns pointer
// RULE18: execute runs target without moving control
// RULE19: software avoids unsuitable execute targets
// RULE20: faults leave architectural state unchanged
// RULE21: missing arguments get omitted pointers
`timescale 1ns/1ps
module pcs_unit import pcs_pkg::*; (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // command from decode
  input wire logic cmd_valid,
  input wire pcs_op_t cmd_op,
  input wire pcs_ptr_t cmd_ea,
  input wire logic [7:0] cmd_args,
  input wire pcs_arch_t cur,
  input wire logic ecb_read_ok,
  input wire logic ecb_gate_ok,
  // segmented memory
  output pcs_mreq_t mem,
  input wire logic mem_ack,
  input wire logic [15:0] mem_rdata,
  // results
  output logic busy,
  output logic done,
  output logic fault,
  output pcs_fault_t fault_code,
  output pcs_arch_t arch,
  output logic exec_go,
  output pcs_ptr_t exec_addr
);
  typedef enum logic [3:0] {
    st_idle, st_ecb, st_fprd, st_alloc, st_extrd, st_fpwr, st_hdr,
    st_argrd, st_argwr, st_pbwr, st_prfree, st_prrd, st_rtnrd, st_done
  } pcs_state_t;

  // pointer plus word offset
  function automatic pcs_ptr_t padd(input pcs_ptr_t p, input logic [15:0] o);
    padd = '{seg: p.seg, word: p.word + o};
  endfunction : padd

  // replace ring bits of a segment word
  function automatic logic [15:0] set_ring(input logic [15:0] s, input logic [1:0] r);
    set_ring = s;
    set_ring[RING_HI:RING_LO] = r;
  endfunction : set_ring

  // frame header word for index i
  function automatic logic [15:0] hdr_word(input logic [15:0] i, input pcs_arch_t c);
    case (i)
      HDR_PB: hdr_word = c.pc.seg;
      HDR_PB + 16'h0001: hdr_word = c.pc.word + PCL_LEN;
      HDR_SB: hdr_word = c.sb.seg;
      HDR_SB + 16'h0001: hdr_word = c.sb.word;
      HDR_LB: hdr_word = c.lb.seg;
      HDR_LB + 16'h0001: hdr_word = c.lb.word;
      HDR_KEYS: hdr_word = c.keys;
      HDR_PC_WORD: hdr_word = c.pc.word + PCL_LEN;
      default: hdr_word = 16'h0000;
    endcase
  endfunction : hdr_word

  pcs_state_t st, next_st; // sequencer state
  logic [15:0] idx, next_idx; // word counter
  logic iss, next_iss; // request issued
  pcs_op_t op, next_op; // operation in flight
  pcs_ptr_t ea, next_ea; // effective address
  logic [15:0] sup, next_sup; // supplied templates
  logic [15:0] size, next_size; // frame size wanted
  logic [15:0] root, next_root; // stack root segment
  pcs_ptr_t fp, next_fp; // free pointer
  pcs_ptr_t frm, next_frm; // new frame
  logic gate, next_gate; // call through gate
  logic [15:0] tmp, next_tmp; // scratch word
  logic [15:0] wbuf [0:7]; // block or frame words
  logic [15:0] next_wbuf [0:7];
  pcs_arch_t cap, next_cap; // state at start
  pcs_mreq_t next_mem, acc;
  pcs_arch_t next_arch;
  pcs_fault_t next_code;
  pcs_ptr_t next_xaddr;
  logic next_busy, next_done, next_fault, next_xgo, ack_ok;
  logic [16:0] sum;
  logic [15:0] nk;

  // memory access for current state
  always_comb begin
    acc = '0;
    acc.req = 1'b1;
    case (st)
      st_ecb: acc.addr = padd(ea, idx);
      st_fprd: acc.addr = '{seg: root, word: FP_WORD + idx}; // see RULE5
      st_extrd: acc.addr = '{seg: fp.seg, word: EXT_WORD + idx}; // see RULE6
      st_fpwr: begin
        acc.we = 1'b1;
        acc.addr = '{seg: root, word: FP_WORD + idx};
        acc.wdata = idx[0] ? fp.word : fp.seg; // see RULE5
      end
      st_hdr: begin
        acc.we = 1'b1;
        acc.addr = padd(frm, idx);
        acc.wdata = hdr_word(idx, cap); // see RULE7 see RULE8 see RULE9
      end
      st_argrd: acc.addr = padd(cap.pc, PCL_LEN + {1'b0, idx[15:1]});
      st_argwr: begin
        acc.we = 1'b1;
        acc.addr = padd(frm, ARG_BASE + idx);
        if ({1'b0, idx[15:1]} >= sup) begin
          acc.wdata = OMIT_PTR; // see RULE21
        end else begin
          acc.wdata = idx[0] ? tmp : cap.pc.seg;
        end
      end
      st_pbwr: begin
        acc.we = 1'b1;
        acc.addr = padd(frm, HDR_PB + 16'h0001);
        acc.wdata = cap.pc.word + PCL_LEN + sup; // see RULE11
      end
      st_prfree: begin
        acc.we = 1'b1;
        acc.addr = '{seg: cap.sb.seg, word: FP_WORD + idx};
        acc.wdata = idx[0] ? cap.sb.word : cap.sb.seg; // see RULE13
      end
      st_prrd: acc.addr = padd(cap.sb, HDR_PB + idx);
      st_rtnrd: acc.addr = '{seg: cap.sb.seg, word: cap.s + (idx == 16'h0000 ? RTN_PC_OFS : 16'h0000)};
      default: acc = '0;
    endcase
  end

  // next state of the sequencer
  always_comb begin
    next_st = st;
    next_idx = idx;
    next_iss = iss;
    next_mem = mem;
    next_op = op;
    next_ea = ea;
    next_sup = sup;
    next_size = size;
    next_root = root;
    next_fp = fp;
    next_frm = frm;
    next_gate = gate;
    next_tmp = tmp;
    next_wbuf = wbuf;
    next_cap = cap;
    next_arch = arch;
    next_code = fault_code;
    next_xaddr = exec_addr;
    next_done = 1'b0;
    next_fault = 1'b0;
    next_xgo = 1'b0;
    ack_ok = 1'b0;
    sum = {1'b0, fp.word} + {1'b0, size};
    nk = {1'b0, idx[15:1]} + 16'h0001;
    // request handshake, held until ack
    if (st != st_idle && st != st_alloc && st != st_done) begin
      if (!iss) begin
        next_mem = acc;
        next_iss = 1'b1;
      end else if (mem_ack) begin
        next_mem.req = 1'b0;
        next_iss = 1'b0;
        ack_ok = 1'b1;
      end
    end
    case (st)
      st_idle: if (cmd_valid) begin
        next_cap = cur;
        next_op = cmd_op;
        next_ea = cmd_ea;
        next_sup = {8'h00, cmd_args};
        next_idx = 16'h0000;
        next_code = fault_none;
        next_st = st_done;
        case (cmd_op)
          jump_save_word_number: begin
            next_arch = cur;
            next_arch.y = cur.pc.word; // see RULE1
            next_arch.pc = cmd_ea;
          end
          execute_at_address_op: begin
            next_arch = cur; // see RULE18
            next_xgo = 1'b1;
            next_xaddr = cmd_ea;
          end
          procedure_call_op: begin
            if (ecb_read_ok) begin
              next_gate = 1'b0; // see RULE2
              next_st = st_ecb;
            end else if (ecb_gate_ok && (cmd_ea.word & GATE_MASK) == 16'h0000) begin
              next_gate = 1'b1; // see RULE3
              next_st = st_ecb;
            end else begin
              next_code = fault_access; // see RULE4
            end
          end
          procedure_return_op: next_st = st_prfree;
          recursive_return_op: next_st = st_rtnrd;
          stack_extend_op: begin
            next_size = (cur.l[15:0] + 16'h0001) & 16'hFFFE; // see RULE17
            next_root = cur.sb.seg;
            next_st = st_fprd;
          end
          default: next_code = fault_access;
        endcase
      end
      // read entry control block
      st_ecb: if (ack_ok) begin
        next_wbuf[idx[2:0]] = mem_rdata;
        next_idx = idx + 16'h0001;
        if (idx == ECB_LEN - 16'h0001) begin
          next_root = (wbuf[ECB_ROOT[2:0]] != 16'h0000) ? wbuf[ECB_ROOT[2:0]] : cap.sb.seg;
          next_size = wbuf[ECB_SIZE[2:0]];
          next_idx = 16'h0000;
          next_st = st_fprd;
        end
      end
      // fetch free pointer
      st_fprd: if (ack_ok) begin
        next_idx = idx + 16'h0001;
        if (idx == 16'h0000) begin
          next_fp.seg = mem_rdata;
        end else begin
          next_fp.word = mem_rdata;
          next_idx = 16'h0000;
          next_st = st_alloc;
        end
      end
      // room check
      st_alloc: if (!sum[16]) begin
        next_frm = fp; // see RULE5
        next_fp.word = sum[15:0];
        next_st = st_fpwr;
      end else begin
        next_st = st_extrd;
      end
      // follow extension pointer
      st_extrd: if (ack_ok) begin
        next_idx = idx + 16'h0001;
        if (idx == 16'h0000) begin
          next_tmp = mem_rdata;
        end else if (tmp == 16'h0000 && mem_rdata == 16'h0000) begin
          next_code = fault_overflow; // see RULE6
          next_st = st_done;
        end else begin
          next_fp = '{seg: tmp, word: mem_rdata}; // see RULE6
          next_idx = 16'h0000;
          next_st = st_alloc;
        end
      end
      // store advanced free pointer
      st_fpwr: if (ack_ok) begin
        next_idx = idx + 16'h0001;
        if (idx != 16'h0000) begin
          next_idx = 16'h0000;
          if (op == stack_extend_op) begin
            next_arch = cap;
            next_arch.l = frm; // see RULE17
            next_st = st_done;
          end else begin
            next_st = st_hdr;
          end
        end
      end
      // write frame header
      st_hdr: if (ack_ok) begin
        next_idx = idx + 16'h0001;
        if (idx == HDR_LEN - 16'h0001) begin
          next_idx = 16'h0000;
          if (wbuf[ECB_ARGUMENT_COUNT_FIELD[2:0]] == 16'h0000) begin
            next_st = st_pbwr; // see RULE11
          end else begin
            next_st = (sup != 16'h0000) ? st_argrd : st_argwr;
          end
        end
      end
      // fetch one template
      st_argrd: if (ack_ok) begin
        next_tmp = mem_rdata;
        next_st = st_argwr;
      end
      // store argument pointer words
      st_argwr: if (ack_ok) begin
        if (!idx[0] && {1'b0, idx[15:1]} < sup) begin
          next_idx = idx + 16'h0001;
        end else begin
          next_idx = {nk[14:0], 1'b0}; // omitted keeps word two
          if (nk >= wbuf[ECB_ARGUMENT_COUNT_FIELD[2:0]]) begin
            next_idx = 16'h0000; // surplus templates ignored, see RULE21
            next_st = st_pbwr;
          end else begin
            next_st = (nk < sup) ? st_argrd : st_argwr;
          end
        end
      end
      // final saved pb, then callee state
      st_pbwr: if (ack_ok) begin
        next_arch = cap;
        next_arch.pc.seg = set_ring(wbuf[0], gate ? wbuf[0][RING_HI:RING_LO]
                                    : cap.pc.seg[RING_HI:RING_LO]); // see RULE10
        next_arch.pc.word = wbuf[1];
        next_arch.lb = '{seg: wbuf[ECB_LB[2:0]], word: wbuf[ECB_LB[2:0] + 3'h1]};
        next_arch.keys = wbuf[ECB_KEYS[2:0]];
        next_arch.sb = frm; // see RULE10
        next_st = st_done;
      end
      // free pointer back to frame start drops extensions too
      st_prfree: if (ack_ok) begin
        next_idx = idx + 16'h0001; // see RULE14
        if (idx != 16'h0000) begin
          next_idx = 16'h0000;
          next_st = st_prrd;
        end
      end
      // reload caller state
      st_prrd: if (ack_ok) begin
        next_wbuf[idx[2:0]] = mem_rdata;
        next_idx = idx + 16'h0001;
        if (idx == PR_LEN - 16'h0001) begin
          next_arch = cap;
          next_arch.pc.seg = (wbuf[0][RING_HI:RING_LO] > cap.pc.seg[RING_HI:RING_LO])
                             ? wbuf[0] : set_ring(wbuf[0], cap.pc.seg[RING_HI:RING_LO]); // see RULE13
          next_arch.pc.word = wbuf[1];
          next_arch.sb = '{seg: wbuf[2], word: wbuf[3]};
          next_arch.lb = '{seg: wbuf[4], word: wbuf[5]};
          next_arch.keys = mem_rdata;
          next_st = st_done;
        end
      end
      // recursive return
      st_rtnrd: if (ack_ok) begin
        next_idx = idx + 16'h0001;
        if (idx != 16'h0000) begin
          next_arch = cap;
          next_arch.pc.word = tmp; // see RULE15
          next_arch.s = mem_rdata;
          next_st = st_done;
        end else if (mem_rdata == 16'h0000) begin
          next_code = stack_underflow_fault; // see RULE16
          next_st = st_done;
        end else begin
          next_tmp = mem_rdata;
        end
      end
      // report, undo on fault
      st_done: begin
        next_done = 1'b1;
        next_fault = (fault_code != fault_none);
        if (fault_code != fault_none) begin
          next_arch = cap; // see RULE20
        end
        next_st = st_idle;
      end
      default: next_st = st_idle;
    endcase
    next_busy = (next_st != st_idle);
  end

  // registers
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st <= st_idle;
      idx <= 16'h0000;
      iss <= 1'b0;
      mem <= '0;
      op <= jump_save_word_number;
      ea <= '0;
      sup <= 16'h0000;
      size <= 16'h0000;
      root <= 16'h0000;
      fp <= '0;
      frm <= '0;
      gate <= 1'b0;
      tmp <= 16'h0000;
      wbuf <= '{default: 16'h0000};
      cap <= '0;
      arch <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      fault <= 1'b0;
      fault_code <= fault_none;
      exec_go <= 1'b0;
      exec_addr <= '0;
    end else begin
      st <= next_st;
      idx <= next_idx;
      iss <= next_iss;
      mem <= next_mem;
      op <= next_op;
      ea <= next_ea;
      sup <= next_sup;
      size <= next_size;
      root <= next_root;
      fp <= next_fp;
      frm <= next_frm;
      gate <= next_gate;
      tmp <= next_tmp;
      wbuf <= next_wbuf;
      cap <= next_cap;
      arch <= next_arch;
      busy <= next_busy;
      done <= next_done;
      fault <= next_fault;
      fault_code <= next_code;
      exec_go <= next_xgo;
      exec_addr <= next_xaddr;
    end
  end

  // checks
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire take = cmd_valid && !busy;
  chk_jsy_word: assert property (take && cmd_op == jump_save_word_number
    |=> arch.y == $past(cur.pc.word) ##1 done && !fault) else $error("y not saved"); // see RULE1
  chk_gate_align: assert property (take && cmd_op == procedure_call_op && !ecb_read_ok
    && ecb_gate_ok && cmd_ea.word[3:0] != 4'h0 |=> ##1 fault && fault_code == fault_access)
    else $error("unaligned gate accepted"); // see RULE3
  chk_no_access: assert property (take && cmd_op == procedure_call_op && !ecb_read_ok
    && !ecb_gate_ok |=> ##1 done && fault) else $error("no access not faulted"); // see RULE4
  chk_flag_zero: assert property (st == st_hdr && mem.req && mem.addr == frm
    |-> mem.we && mem.wdata == 16'h0000) else $error("flag word not zero"); // see RULE7
  chk_word_11: assert property (st == st_hdr && mem.req && mem.addr.word == frm.word + HDR_PC_WORD
    |-> mem.wdata == cap.pc.word + PCL_LEN) else $error("return word wrong"); // see RULE9
  chk_fault_undo: assert property (done && fault |-> arch == cap)
    else $error("fault changed state"); // see RULE20
  chk_psu_keep: assert property (fault_code == stack_underflow_fault && done |-> arch.s == cap.s)
    else $error("s changed on underflow"); // see RULE16
  chk_stack_extend_op_even: assert property (st == st_alloc && op == stack_extend_op |-> !size[0])
    else $error("extend size odd"); // see RULE17
  chk_ring_weak: assert property (done && !fault && op == procedure_return_op
    |-> arch.pc.seg[RING_HI:RING_LO] >= cap.pc.seg[RING_HI:RING_LO]) else $error("ring strengthened"); // see RULE13
  chk_req_hold: assert property (mem.req && !mem_ack |=> mem.req && $stable(mem.addr))
    else $error("request dropped");
  cov_call: cover property (done && !fault && op == procedure_call_op);
  cov_ext: cover property (st == st_extrd ##1 st == st_extrd);
  cov_ret: cover property (done && !fault && op == procedure_return_op);
  cov_psu: cover property (done && fault_code == stack_underflow_fault);
endmodule : pcs_unit

// File: tb/pcs_mem_model.sv
// Purpose: segmented memory partner holding stack frames
// Assumes: one request at a time, held until ack
// Notes: lat sets wait cycles before each ack
`timescale 1ns/1ps
module pcs_mem_model import pcs_pkg::*; (
  // clock
  input wire logic mclk,
  // request side
  input wire pcs_mreq_t mem,
  input wire logic [1:0] lat,
  // answer side
  output logic mem_ack,
  output logic [15:0] mem_rdata
);
  logic [15:0] m [logic [31:0]]; // sparse word store
  logic [1:0] cnt; // wait counter
  // unwritten words read as zero
  function automatic logic [15:0] peek(input logic [31:0] a);
    return m.exists(a) ? m[a] : 16'h0000;
  endfunction : peek
  // preload from the bench
  task automatic poke(input logic [31:0] a, input logic [15:0] d);
    m[a] = d;
  endtask : poke
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 16'h5A5A;
    cnt = 2'h0;
  end
  // answer a held request after lat cycles
  always @(posedge mclk) begin
    #1;
    mem_rdata = ~mem_rdata; // stale data inverts every cycle
    if (mem_ack) begin
      mem_ack = 1'b0;
    end else if (mem.req) begin
      if (cnt == lat) begin
        cnt = 2'h0;
        mem_ack = 1'b1;
        if (mem.we) m[mem.addr] = mem.wdata;
        else mem_rdata = peek(mem.addr);
      end else cnt = cnt + 2'h1;
    end
  end
endmodule : pcs_mem_model

// File: tb/testbench.sv
// Purpose: self-checking bench of the procedure call stack unit
// Assumes: memory partner answers with random latency
// Notes: expectations worked out from frame layout
`timescale 1ns/1ps
module testbench import pcs_pkg::*; ;
  logic mclk, reset_n, cmd_valid, ecb_read_ok, ecb_gate_ok, mem_ack;
  logic busy, done, fault, exec_go, xg; // outputs and exec capture
  pcs_op_t cmd_op; // command
  pcs_ptr_t cmd_ea, exec_addr, xa, fr; // addresses
  logic [7:0] cmd_args;
  pcs_arch_t cur, arch; // state in and out
  pcs_mreq_t mem;
  logic [15:0] mem_rdata, rs, ret;
  logic [15:0] fw [9]; // frame words
  pcs_fault_t fault_code;
  logic [1:0] lat, rg;
  int fails, check_count, seed, ncyc;
  pcs_unit pcs_unit_i (.mclk(mclk), .reset_n(reset_n), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_ea(cmd_ea), .cmd_args(cmd_args), .cur(cur), .ecb_read_ok(ecb_read_ok),
    .ecb_gate_ok(ecb_gate_ok), .mem(mem), .mem_ack(mem_ack), .mem_rdata(mem_rdata), .busy(busy),
    .done(done), .fault(fault), .fault_code(fault_code), .arch(arch), .exec_go(exec_go),
    .exec_addr(exec_addr));
  pcs_mem_model pcs_mem_model_i (.mclk(mclk), .mem(mem), .lat(lat), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  // clock
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // memory access shorthands
  function automatic logic [15:0] pk(input logic [15:0] s, input logic [15:0] w);
    return pcs_mem_model_i.peek({s, w});
  endfunction : pk
  task automatic wr(input logic [15:0] s, input logic [15:0] w, input logic [15:0] d);
    pcs_mem_model_i.poke({s, w}, d);
  endtask : wr
  // value compare
  task automatic cmp(input logic [175:0] got, input logic [175:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask : cmp
  // verdict
  task automatic final_report;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report
  // random caller state and latency
  task automatic rnd;
    cur.pc = $random(seed);
    cur.sb = $random(seed);
    cur.lb = $random(seed);
    cur.keys = 16'($random(seed));
    cur.y = 16'($random(seed));
    cur.s = 16'($random(seed));
    cur.l = $random(seed);
    lat = 2'($random(seed));
  endtask : rnd
  // one command, held for one cycle, then wait for done
  task automatic run(input pcs_op_t op, input pcs_ptr_t ea, input logic [7:0] n, input logic r,
                     input logic g);
    @(posedge mclk);
    #1;
    cmd_op = op;
    cmd_ea = ea;
    cmd_args = n;
    ecb_read_ok = r;
    ecb_gate_ok = g;
    cmd_valid = 1'b1;
    xg = 1'b0;
    ncyc = 0;
    do begin
      @(posedge mclk);
      #1;
      cmd_valid = 1'b0;
      ncyc++;
      if (exec_go === 1'b1) begin
        xg = 1'b1;
        xa = exec_addr;
      end
    end while (done !== 1'b1 && ncyc < 400);
    cmp(done, 1'b1, "done");
  endtask : run
  // call with read or gate access, room or extension
  task automatic do_call(input logic g, input logic [15:0] fpw, input logic [15:0] xs,
                         input logic [7:0] na, input logic [7:0] ca);
    rnd;
    rs = g ? 16'h0200 : cur.sb.seg;
    wr(16'h0300, 16'h0040, 16'h2400); // callee ring 1 in pb seg
    wr(16'h0300, 16'h0041, 16'h1000);
    wr(16'h0300, 16'h0042, 16'h0020); // frame size
    wr(16'h0300, 16'h0043, g ? 16'h0200 : 16'h0000); // stack root
    wr(16'h0300, 16'h0044, {8'h00, na});
    wr(16'h0300, 16'h0045, 16'h0500);
    wr(16'h0300, 16'h0046, 16'h0600);
    wr(16'h0300, 16'h0047, 16'hC3A5);
    wr(rs, 16'h0000, 16'h0700);
    wr(rs, 16'h0001, fpw);
    wr(16'h0700, 16'h0002, xs);
    wr(16'h0700, 16'h0003, (xs == 16'h0000) ? 16'h0000 : 16'h0100); // zero pointer ends the chain
    fr = (fpw > 16'hFFDF) ? {xs, 16'h0100} : {16'h0700, fpw};
    run(procedure_call_op, {16'h0300, 16'h0040}, ca, !g, g);
    if (fr.seg == 16'h0000) begin
      cmp({fault, fault_code}, {1'b1, fault_overflow}, "overflow");
      cmp(arch, cur, "state kept");
    end else begin
      cmp({pk(rs, 16'h0000), pk(rs, 16'h0001)}, {fr.seg, 16'(fr.word + 16'h0020)}, "fp");
      cmp(pk(fr.seg, fr.word), 16'h0000, "flag");
      cmp(pk(fr.seg, 16'(fr.word + 16'h0002)), cur.pc.seg, "saved pb");
      cmp({pk(fr.seg, 16'(fr.word + 16'h0004)), pk(fr.seg, 16'(fr.word + 16'h0005)),
           pk(fr.seg, 16'(fr.word + 16'h0006)), pk(fr.seg, 16'(fr.word + 16'h0007)),
           pk(fr.seg, 16'(fr.word + 16'h0008))}, {cur.sb, cur.lb, cur.keys}, "hdr");
      cmp(pk(fr.seg, 16'(fr.word + HDR_PC_WORD)), 16'(cur.pc.word + 16'h0002), "pc+2");
      cmp(pk(fr.seg, 16'(fr.word + 16'h0003)), 16'(cur.pc.word + 16'h0002 + ca), "pb");
      rs = g ? 16'h2400 : {1'b0, cur.pc.seg[14:13], 13'h0400};
      cmp({arch.pc, arch.lb, arch.keys, arch.sb}, {rs, 16'h1000, 16'h0500, 16'h0600, 16'hC3A5, fr},
          "callee");
      if (na > ca) cmp(pk(fr.seg, 16'(fr.word + ARG_BASE + 2 * ca)), OMIT_PTR, "omit");
      if (na != 0 && ca != 0) cmp({pk(fr.seg, 16'(fr.word + ARG_BASE)), pk(fr.seg, 16'(fr.word + ARG_BASE + 1))},
          {cur.pc.seg, pk(cur.pc.seg, 16'(cur.pc.word + 16'h0002))}, "arg ptr");
    end
  endtask : do_call
  // watchdog
  initial begin
    #(100 * 50000);
    fails++;
    final_report;
  end
  // main sequence
  initial begin
    {cmd_valid, ecb_read_ok, ecb_gate_ok, cmd_args, cmd_ea, cur, lat} = '0;
    cmd_op = jump_save_word_number;
    fails = 0;
    check_count = 0;
    seed = 32'he8a129d9;
    reset_n = 1'b0;
    repeat (10) @(posedge mclk);
    #1;
    reset_n = 1'b1;
    repeat (4) begin
      rnd;
      fr = $random(seed);
      run(jump_save_word_number, fr, 8'h00, 1'b0, 1'b0);
      cmp({arch.y, arch.pc, 8'(ncyc)}, {cur.pc.word, fr, 8'h02}, "jump save");
      run(execute_at_address_op, fr, 8'h00, 1'b0, 1'b0);
      cmp({xg, xa, arch.pc}, {1'b1, fr, cur.pc}, "execute");
    end
    $display("test jump and execute done");
    rnd;
    run(procedure_call_op, {16'h0300, 16'h0040}, 8'h00, 1'b0, 1'b0);
    cmp({fault, fault_code, 8'(ncyc)}, {1'b1, fault_access, 8'h02}, "access");
    cmp(arch, cur, "state kept");
    run(procedure_call_op, {16'h0300, 16'h0041}, 8'h00, 1'b0, 1'b1);
    cmp({fault, fault_code}, {1'b1, fault_access}, "gate align");
    do_call(1'b0, 16'h1000, 16'h0000, 8'h00, 8'h00);
    do_call(1'b1, 16'hFFF0, 16'h0800, 8'h02, 8'h01);
    do_call(1'b0, 16'hFFF0, 16'h0000, 8'h00, 8'h00);
    $display("test calls done");
    rnd;
    cur.sb = {16'h0900, 16'h0200};
    for (int i = 2; i < 9; i++) begin
      fw[i] = 16'($random(seed));
      wr(16'h0900, 16'(16'h0200 + i), fw[i]);
    end
    run(procedure_return_op, '0, 8'h00, 1'b0, 1'b0);
    cmp({pk(16'h0900, 16'h0000), pk(16'h0900, 16'h0001)}, cur.sb, "free");
    rg = (fw[2][14:13] > cur.pc.seg[14:13]) ? fw[2][14:13] : cur.pc.seg[14:13];
    cmp(arch.pc, {fw[2][15], rg, fw[2][12:0], fw[3]}, "ret pc");
    cmp({arch.sb, arch.lb, arch.keys}, {fw[4], fw[5], fw[6], fw[7], fw[8]}, "ret st");
    $display("test return done");
    for (int z = 0; z < 2; z++) begin
      rnd;
      cur.s = 16'h0400;
      ret = z ? 16'h0000 : 16'($random(seed)) | 16'h0001;
      wr(cur.sb.seg, 16'h0401, ret);
      wr(cur.sb.seg, 16'h0400, 16'h0333);
      run(recursive_return_op, '0, 8'h00, 1'b0, 1'b0);
      if (z) cmp({fault_code, arch.s}, {stack_underflow_fault, cur.s}, "underflow");
      else cmp({arch.pc.word, arch.s}, {ret, 16'h0333}, "rec ret");
    end
    $display("test recursive return done");
    rnd;
    cur.sb.seg = 16'h0A00;
    cur.l[15:0] = 16'h0013;
    wr(16'h0A00, 16'h0000, 16'h0B00);
    wr(16'h0A00, 16'h0001, 16'h0300);
    run(stack_extend_op, '0, 8'h00, 1'b0, 1'b0);
    cmp({arch.l, pk(16'h0A00, 16'h0001)}, {16'h0B00, 16'h0300, 16'h0314}, "extend");
    $display("test stack extend done");
    final_report;
  end
endmodule : testbench
